// *** rtl/psepmc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module psepmc_top #(
    parameter int CADENCE_CYCLES = psepmc_pkg::CADENCE_CYC,
    parameter int PROBE_CYCLES   = psepmc_pkg::PROBE_GAP_CYC
) (
    input  wire logic       CORE_CLK,
    input  wire logic       SYS_RST,
    input  wire logic       HW_EN_N,
    input  wire logic [7:0] DIE_TEMP_C,
    input  wire logic [3:0] ADDR_STRAP,
    input  wire logic       CADENCE_STRAP,
    input  wire logic       TIER5_STRAP,
    input  wire logic       MODE_STRAP,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic [3:0] SIG_GOOD,
    input  wire logic [3:0] CLASS_GOOD,
    output logic      [3:0] PORT_POWER,
    output logic      [3:0] PROBE_ACTIVE,
    output logic      [3:0] CLASS_ACTIVE,
    output logic      [3:0] DEV_ADDR,
    output logic            TIER5_EN,
    output logic            THERM_SHDN
);
    // reset sources and release tracking
    logic        soft_rst_r;
    logic        therm_r;
    logic        in_rst;
    logic        in_rst_d_r;
    logic        rst_end;
    logic        auto_rst_r;
    assign in_rst  = SYS_RST | ~HW_EN_N | soft_rst_r | therm_r;
    assign rst_end = in_rst_d_r & ~in_rst;

    // thermal hysteresis; leaving it passes through reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            therm_r <= 1'b0;
        end else if (DIE_TEMP_C >= 8'(psepmc_pkg::THERM_HI_C)) begin
            therm_r <= 1'b1;
        end else if (DIE_TEMP_C < 8'(psepmc_pkg::THERM_LO_C)) begin
            therm_r <= 1'b0;
        end
    end

    // soft reset self-clears after one cycle
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= REG_WR && REG_ADDR == psepmc_pkg::ADDR_RESET
                && REG_WDATA[psepmc_pkg::SOFT_RST_BIT];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            in_rst_d_r <= 1'b1;
        end else begin
            in_rst_d_r <= in_rst;
        end
    end

    // straps latched only at the end of any reset
    logic       cad_strap_r;
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            DEV_ADDR    <= 4'h0;
            TIER5_EN    <= 1'b0;
            cad_strap_r <= 1'b0;
            auto_rst_r  <= 1'b0;
        end else if (rst_end) begin
            DEV_ADDR    <= ADDR_STRAP;
            TIER5_EN    <= TIER5_STRAP;
            cad_strap_r <= CADENCE_STRAP;
            auto_rst_r  <= MODE_STRAP;
        end
    end
    assign THERM_SHDN = therm_r;

    // register bus decode
    logic wr_mode;
    logic wr_run;
    logic wr_cad;
    logic wr_pwr;
    logic wr_prst;
    logic rd_cor;
    assign wr_mode = REG_WR && REG_ADDR == psepmc_pkg::ADDR_MODE;
    assign wr_run  = REG_WR && REG_ADDR == psepmc_pkg::ADDR_RUN;
    assign wr_cad  = REG_WR && REG_ADDR == psepmc_pkg::ADDR_CADENCE;
    assign wr_pwr  = REG_WR && REG_ADDR == psepmc_pkg::ADDR_PWR_CMD;
    assign wr_prst = REG_WR && REG_ADDR == psepmc_pkg::ADDR_RESET;
    assign rd_cor  = REG_RD && REG_ADDR == psepmc_pkg::ADDR_EVENT_COR;

    logic [7:0] mode_r;
    logic [3:0] cad_r;
    logic [7:0] run_r;
    logic [7:0] run_nxt;
    logic [3:0] det_evt_r;
    logic [3:0] det_evt_set;
    logic [3:0] pwr_dn;
    logic [3:0] run_done_p;
    logic [3:0] run_done_c;
    logic [3:0] port_clr;

    // true when a two-bit mode field holds the given mode
    function automatic logic mode_is(input logic [1:0]               fld,
                                     input psepmc_pkg::psepmc_mode_t m);
        return fld == 2'(m);
    endfunction

    // mode register; default chosen by mode strap at reset release
    always_ff @(posedge CORE_CLK) begin
        if (in_rst) begin
            mode_r <= psepmc_pkg::MODE_SHDN_RST;
        end else if (rst_end) begin
            mode_r <= MODE_STRAP ? psepmc_pkg::MODE_AUTO_RST
                                 : psepmc_pkg::MODE_SHDN_RST;
        end else if (wr_mode) begin
            mode_r <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (in_rst) begin
            cad_r <= 4'h0;
        end else if (wr_cad) begin
            cad_r <= REG_WDATA[3:0];
        end
    end

    // run bits: auto from reset sets, manual entry clears, one-shots
    always_comb begin
        run_nxt = run_r;
        if (wr_run) begin
            run_nxt = REG_WDATA;
        end
        for (int p = 0; p < 4; p++) begin
            if (wr_mode && REG_WDATA[2*p +: 2] == 2'(psepmc_pkg::PSEP_MANUAL)
                && mode_r[2*p +: 2] != 2'(psepmc_pkg::PSEP_MANUAL)) begin
                run_nxt[p] = 1'b0;
                run_nxt[p+psepmc_pkg::TIER_RUN_LSB] = 1'b0;
            end
            if (run_done_p[p]) begin
                run_nxt[p] = 1'b0;
            end
            if (run_done_c[p]) begin
                run_nxt[p+psepmc_pkg::TIER_RUN_LSB] = 1'b0;
            end
            if (pwr_dn[p]) begin
                run_nxt[p] = 1'b0;
                run_nxt[p+psepmc_pkg::TIER_RUN_LSB] = 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (in_rst) begin
            run_r <= 8'h00;
        end else if (rst_end) begin
            run_r <= MODE_STRAP ? psepmc_pkg::RUN_AUTO_RST : 8'h00;
        end else begin
            run_r <= run_nxt;
        end
    end

    // detection events; a new event wins over the read clear,
    // a cleared or shut-down port drops its own bits
    always_ff @(posedge CORE_CLK) begin
        if (in_rst) begin
            det_evt_r <= 4'h0;
        end else begin
            det_evt_r <= (det_evt_r & ~port_clr
                          & ~(rd_cor ? 4'hF : 4'h0)) | det_evt_set;
        end
    end

    // read mux
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            if (REG_ADDR == psepmc_pkg::ADDR_EVENT
                || REG_ADDR == psepmc_pkg::ADDR_EVENT_COR) begin
                REG_RDATA <= {4'h0, det_evt_r};
            end else if (REG_ADDR == psepmc_pkg::ADDR_MODE) begin
                REG_RDATA <= mode_r;
            end else if (REG_ADDR == psepmc_pkg::ADDR_RUN) begin
                REG_RDATA <= run_r;
            end else if (REG_ADDR == psepmc_pkg::ADDR_CADENCE) begin
                REG_RDATA <= {4'h0, cad_r};
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

    // per-port sequencer
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gp
            // per-port state, timer and decodes
            psepmc_pkg::psepmc_state_t    st_r;
            logic [psepmc_pkg::TMR_W-1:0] tmr_r;
            logic [psepmc_pkg::TMR_W-1:0] probe_load;
            logic [psepmc_pkg::TMR_W-1:0] backoff_load;
            logic [1:0]                   md;
            logic                         is_shdn;
            logic                         is_manual;
            logic                         is_semi;
            logic                         is_auto;
            logic                         in_power;
            logic                         probe_req;
            logic                         class_req;
            logic                         pwr_cmd;
            logic                         clr;
            logic                         cad_on;
            logic                         tmo;
            logic                         probe_end;
            logic                         class_end;
            logic                         valid_r;

            // mode field of this port and its decoded flavours
            assign md        = mode_r[2*g +: 2];
            assign is_shdn   = mode_is(md, psepmc_pkg::PSEP_SHDN);
            assign is_manual = mode_is(md, psepmc_pkg::PSEP_MANUAL);
            assign is_semi   = mode_is(md, psepmc_pkg::PSEP_SEMI);
            assign is_auto   = mode_is(md, psepmc_pkg::PSEP_AUTO);

            // run and power requests for this port
            assign probe_req = run_r[g];
            assign class_req = run_r[g+psepmc_pkg::TIER_RUN_LSB];
            assign pwr_cmd   = wr_pwr && REG_WDATA[g];

            // timer reload values, cut to the timer width on purpose
            assign probe_load   = psepmc_pkg::TMR_W'(PROBE_CYCLES - 1);
            assign backoff_load = psepmc_pkg::TMR_W'(CADENCE_CYCLES - 1);
            assign tmo          = tmr_r == '0;

            // state decodes shared by the outputs below
            assign in_power  = st_r == psepmc_pkg::PSEP_POWER;
            assign probe_end = st_r == psepmc_pkg::PSEP_PROBE2 && tmo;
            assign class_end = st_r == psepmc_pkg::PSEP_CLASS && tmo;

            // port clear acts only on a powered port; shutdown always
            assign clr = (wr_prst && REG_WDATA[g] && in_power)
                         || is_shdn;
            assign port_clr[g] = clr;
            assign cad_on      = cad_strap_r | cad_r[g];

            // event and run-bit strobes toward the shared registers
            assign det_evt_set[g] = probe_end && !clr;
            assign pwr_dn[g]      = in_power && clr && is_semi;
            assign run_done_p[g]  = is_manual && probe_end;
            assign run_done_c[g]  = is_manual && class_end;

            // status outputs decoded from the state flops
            assign PORT_POWER[g]   = in_power;
            assign PROBE_ACTIVE[g] = st_r == psepmc_pkg::PSEP_PROBE1
                                     || st_r == psepmc_pkg::PSEP_PROBE2;
            assign CLASS_ACTIVE[g] = st_r == psepmc_pkg::PSEP_CLASS;

            // remembers a good classify for the power command; a failed probe clears it
            always_ff @(posedge CORE_CLK) begin
                if (in_rst || clr) begin
                    valid_r <= 1'b0;
                end else if (probe_end && !SIG_GOOD[g]) begin
                    // a failed probe forgets the earlier result
                    valid_r <= 1'b0;
                end else if (class_end) begin
                    valid_r <= CLASS_GOOD[g];
                end
            end

            // state and timer; port clear or shutdown returns to idle
            always_ff @(posedge CORE_CLK) begin
                if (in_rst || clr) begin
                    st_r  <= psepmc_pkg::PSEP_IDLE;
                    tmr_r <= '0;
                end else if (is_manual && pwr_cmd) begin
                    // manual power command beats every other request
                    st_r <= psepmc_pkg::PSEP_POWER;
                end else if (is_semi && pwr_cmd && valid_r) begin
                    // semiautomatic powers only a validated port
                    st_r <= psepmc_pkg::PSEP_POWER;
                end else begin
                    // timer counts down to zero and rests there
                    if (!tmo) begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                    case (st_r)
                        psepmc_pkg::PSEP_IDLE: begin
                            // detection is taken before classification
                            if (probe_req) begin
                                st_r  <= psepmc_pkg::PSEP_PROBE1;
                                tmr_r <= probe_load;
                            end else if (class_req && !is_auto) begin
                                st_r  <= psepmc_pkg::PSEP_CLASS;
                                tmr_r <= probe_load;
                            end
                        end

                        psepmc_pkg::PSEP_PROBE1: begin
                            // second probe point only after the full gap
                            if (tmo) begin
                                st_r  <= psepmc_pkg::PSEP_PROBE2;
                                tmr_r <= probe_load;
                            end
                        end

                        psepmc_pkg::PSEP_PROBE2: begin
                            // signature judged at the end of the second point
                            if (tmo) begin
                                if (!SIG_GOOD[g]) begin
                                    // failed probe waits out the back-off when cadence is on, else goes back to idle
                                    st_r  <= cad_on ? psepmc_pkg::PSEP_BACKOF
                                                    : psepmc_pkg::PSEP_IDLE;
                                    tmr_r <= backoff_load;
                                end else if (class_req) begin
                                    st_r  <= psepmc_pkg::PSEP_CLASS;
                                    tmr_r <= probe_load;
                                end else begin
                                    st_r <= psepmc_pkg::PSEP_IDLE;
                                end
                            end
                        end

                        psepmc_pkg::PSEP_CLASS: begin
                            // only auto mode powers on its own
                            if (tmo) begin
                                if (!CLASS_GOOD[g]) begin
                                    st_r <= psepmc_pkg::PSEP_IDLE;
                                end else if (is_auto) begin
                                    st_r <= psepmc_pkg::PSEP_POWER;
                                end else begin
                                    st_r <= psepmc_pkg::PSEP_READY;
                                end
                            end
                        end

                        psepmc_pkg::PSEP_READY: begin
                            // validated port waits for power or a new probe
                            if (pwr_cmd) begin
                                st_r <= psepmc_pkg::PSEP_POWER;
                            end else if (probe_req) begin
                                st_r  <= psepmc_pkg::PSEP_PROBE1;
                                tmr_r <= probe_load;
                            end
                        end

                        psepmc_pkg::PSEP_BACKOF: begin
                            // cadence pause before the next attempt
                            if (tmo) begin
                                st_r <= psepmc_pkg::PSEP_IDLE;
                            end
                        end

                        default: begin
                            // powered ports ignore run bits
                            st_r <= st_r;
                        end
                    endcase
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** rtl/psepmc_pkg.sv ***
// Notes on behaviour
// - writing one to soft reset bit 4 of register 1Ah resets whole device.
// - thermal shutdown at 140 C; leave through full reset below 120 C.
// - address, cadence, tier-5 and mode straps sampled only when reset ends.
// - port clear bit on a powered port turns it off, stops probing, clears status.
// - port clear on an unpowered port does nothing; never a global reset.
// - with cadence active, wait at least 2 s after failed detection.
// - cadence on for all ports if strap high; else per-port bits 15h[3:0].
// - mode field 11 auto, 10 semiautomatic, 01 manual, 00 shutdown.
// - switching among active modes keeps port state; shutdown halts at once.
// - auto mode detects, classifies, powers a valid device, else repeats detection.
// - auto from reset sets run bits; auto by software keeps them.
// - semiautomatic keeps run bits, repeats enabled steps, never powers by itself.
// - semiautomatic power command powers only after good detect and classify; code also powers after a good classify alone, with no detect run.
// - semiautomatic power-down clears that port's run bits.
// - manual entry clears run register; run bits are one-shot pushbuttons.
// - manual power command wins over all and powers the port at once.
// - manual detection before classification; run bits ignored while powered.
// - shutdown removes power, clears status, ignores run and power commands.
// - each detection sets event bit in 04h/05h; cleared by reading 05h or reset.
// - detection keeps switch off, two probes, accept 19 to 26.5 kilohm.
// - detection measurement points at least 2 ms apart.
// - mode strap open selects auto after reset, tied low selects shutdown.
package psepmc_pkg;
    localparam logic [7:0] ADDR_EVENT     = 8'h04;
    localparam logic [7:0] ADDR_EVENT_COR = 8'h05;
    localparam logic [7:0] ADDR_MODE      = 8'h12;
    localparam logic [7:0] ADDR_RUN       = 8'h14;
    localparam logic [7:0] ADDR_CADENCE   = 8'h15;
    localparam logic [7:0] ADDR_PWR_CMD   = 8'h19;
    localparam logic [7:0] ADDR_RESET     = 8'h1A;
    localparam int         SOFT_RST_BIT   = 4;
    localparam int         TIER_RUN_LSB   = 4;
    localparam logic [7:0] RUN_AUTO_RST   = 8'hFF;
    localparam logic [7:0] MODE_AUTO_RST  = 8'hFF;
    localparam logic [7:0] MODE_SHDN_RST  = 8'h00;
    localparam int         CLK_HZ         = 20000000;
    localparam int         HWRST_US       = 100;
    localparam int         HWRST_CYC      = (HWRST_US * (CLK_HZ / 1000000));
    localparam int         PROBE_GAP_MS   = 2;
    localparam int         PROBE_GAP_CYC  = PROBE_GAP_MS * (CLK_HZ / 1000);
    localparam int         CADENCE_S      = 2;
    localparam int         CADENCE_CYC    = CADENCE_S * CLK_HZ;
    localparam int         TMR_W          = 26;
    localparam int         THERM_HI_C     = 140;
    localparam int         THERM_LO_C     = 120;
    typedef enum logic [1:0] {
        PSEP_SHDN   = 2'b00,
        PSEP_MANUAL = 2'b01,
        PSEP_SEMI   = 2'b10,
        PSEP_AUTO   = 2'b11
    } psepmc_mode_t;
    typedef enum logic [2:0] {
        PSEP_IDLE   = 3'b000,
        PSEP_PROBE1 = 3'b001,
        PSEP_PROBE2 = 3'b010,
        PSEP_CLASS  = 3'b011,
        PSEP_READY  = 3'b100,
        PSEP_POWER  = 3'b101,
        PSEP_BACKOF = 3'b110
    } psepmc_state_t;
endpackage

// *** test/psepmc_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module psepmc_props #(
    parameter int PROBE_CYCLES = 4
) (
    input wire logic       CORE_CLK,
    input wire logic       SYS_RST,
    input wire logic       HW_EN_N,
    input wire logic [7:0] DIE_TEMP_C,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [3:0] PORT_POWER,
    input wire logic [3:0] PROBE_ACTIVE,
    input wire logic [3:0] CLASS_ACTIVE,
    input wire logic [3:0] DEV_ADDR,
    input wire logic       TIER5_EN,
    input wire logic       THERM_SHDN
);
    localparam logic [15:0] MIN_RUN = 16'(2 * PROBE_CYCLES - 1);
    logic        rst_src;
    logic        wr_rst;
    logic [2:0]  quiet_r;
    logic [15:0] run_r;
    default clocking dclk @(posedge CORE_CLK);
    endclocking
    default disable iff (SYS_RST);
    // any cause of a whole-device reset
    assign wr_rst = REG_WR && REG_ADDR == 8'h1A;
    assign rst_src = SYS_RST | ~HW_EN_N | THERM_SHDN | (DIE_TEMP_C >= 8'h8C)
        | (wr_rst & REG_WDATA[4]);
    // quiet cycles since a reset cause, probe run length of port 0
    always_ff @(posedge CORE_CLK) begin
        quiet_r <= rst_src ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h4};
        run_r <= PROBE_ACTIVE[0] ? run_r + 16'h1 : 16'h0;
    end
    AST_HW_RST: assert property (!HW_EN_N |-> ##[1:3] !PORT_POWER)
        else $error("port powered in hardware reset");
    AST_SOFT_RST: assert property (
        wr_rst && REG_WDATA[4] |-> ##[1:2] !PORT_POWER)
        else $error("port powered after soft reset");
    AST_HOT: assert property (DIE_TEMP_C >= 8'h8C |=> THERM_SHDN)
        else $error("no thermal shutdown");
    AST_HOT_HOLD: assert property (
        THERM_SHDN && DIE_TEMP_C >= 8'h78 |=> THERM_SHDN)
        else $error("thermal shutdown left early");
    AST_STRAP: assert property (
        quiet_r == 3'h4 |-> $stable(DEV_ADDR) && $stable(TIER5_EN))
        else $error("strap latch changed");
    AST_CLEAR: assert property (
        wr_rst && REG_WDATA[4:0] == 5'h01 && PORT_POWER[0]
        |-> ##[1:2] !PORT_POWER[0])
        else $error("port clear left power on");
    AST_SHDN: assert property (
        REG_WR && REG_ADDR == 8'h12 && REG_WDATA[1:0] == 2'h0
        |-> ##[1:2] !PORT_POWER[0] && !PROBE_ACTIVE[0])
        else $error("port active in shutdown");
    AST_SW_OFF: assert property (!(PROBE_ACTIVE & PORT_POWER))
        else $error("port powered while probing");
    AST_GAP: assert property (
        $fell(PROBE_ACTIVE[0]) && CLASS_ACTIVE[0] |-> run_r >= MIN_RUN)
        else $error("probe points too close");
    cover property ($rose(PORT_POWER[0]));
    cover property ($rose(THERM_SHDN));
    cover property ($fell(PROBE_ACTIVE[0]) && CLASS_ACTIVE[0]);
endmodule
`default_nettype wire

// *** test/psepmc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module psepmc_host (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            en_n
);
    // bus idle, reset pin released
    initial begin
        {wr, rd, addr, wdata} = 18'h0;
        en_n = 1'b1;
    end
    // strobe held one edge; released lines show the inverse
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        @(posedge clk) #2;
        {wr, rd, addr, wdata} = {w, !w, a, d};
        @(posedge clk) #2;
        {wr, rd, addr, wdata} = {2'h0, ~a, ~d};
        q = rdata;
    endtask
    // pin held low for the full minimum time
    task automatic hw_reset();
        @(posedge clk) #2;
        en_n = 1'b0;
        repeat (psepmc_pkg::HWRST_CYC) @(posedge clk);
        #2 en_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// *** test/pse_port_mode_control_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module pse_port_mode_control_test;
    localparam int CAD = 20;
    logic       clk, rst, wr, rd, en_n, t5s, t5, therm;
    logic [7:0] temp, addr, wdata, rdata, d, q;
    logic [3:0] as, sg, pwr, prb, cls, dev;
    int         err_total = 0, comparisons = 0, n;
    psepmc_host u_host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wdata), .en_n(en_n));
    psepmc_top #(.CADENCE_CYCLES(CAD), .PROBE_CYCLES(4)) u_dut (
        .CORE_CLK(clk), .SYS_RST(rst), .HW_EN_N(en_n), .DIE_TEMP_C(temp),
        .ADDR_STRAP(as), .CADENCE_STRAP(1'b1), .TIER5_STRAP(t5s),
        .MODE_STRAP(1'b1), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .SIG_GOOD(sg),
        .CLASS_GOOD(4'hF), .PORT_POWER(pwr), .PROBE_ACTIVE(prb),
        .CLASS_ACTIVE(cls), .DEV_ADDR(dev), .TIER5_EN(t5), .THERM_SHDN(therm));
    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    task automatic w(input logic [7:0] a, dd);
        u_host.xfer(1'b1, a, dd, q);
    endtask
    task automatic r(input logic [7:0] a, e);
        u_host.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic pw(input logic [3:0] e);
        for (n = 0; n < 100 && pwr !== e; n++) tick(1);
        chk({4'h0, pwr}, {4'h0, e});
    endtask
    // mode and run register value after reset
    function automatic logic [7:0] dflt(input logic auto_strap);
        return auto_strap ? 8'hFF : 8'h00;
    endfunction
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end
    // main sequence
    initial begin
        n = $urandom(32'h768D);
        rst = 1'b1;
        temp = 8'($urandom_range(100));
        as = 4'($urandom);
        t5s = 1'($urandom);
        sg = 4'hF;
        tick(3);
        rst = 1'b0;
        tick(2);
        chk({3'h0, t5, dev}, {3'h0, t5s, as});
        r(8'h12, dflt(1'b1));
        r(8'h14, dflt(1'b1));
        as = ~as;
        pw(4'hF);
        chk({4'h0, dev}, {4'h0, ~as});
        r(8'h04, 8'h0F);
        r(8'h05, 8'h0F);
        r(8'h05, 8'h00);
        d = 8'($urandom);
        w(8'h15, d);
        r(8'h15, {4'h0, d[3:0]});
        w(8'h1A, 8'h01);
        tick(1);
        chk({dev, pwr}, {~as, 4'hE});
        w(8'h12, 8'hFC);
        w(8'h19, 8'h01);
        tick(2);
        chk({4'h0, pwr | prb}, 8'h0E);
        for (int c = 0; c < 4; c++) begin
            w(8'h12, {2'(c), 6'h3C});
            r(8'h12, {2'(c), 6'h3C});
        end
        w(8'h12, 8'h55);
        r(8'h14, 8'h00);
        w(8'h19, 8'h01);
        tick(1);
        chk({7'h0, pwr[0]}, 8'h01);
        w(8'h14, 8'h11);
        tick(2);
        chk({6'h0, prb[0], cls[0]}, 8'h00);
        w(8'h1A, 8'h10);
        tick(3);
        chk({4'h0, pwr}, 8'h00);
        r(8'h12, 8'hFF);
        w(8'h12, 8'hFE);
        tick(40);
        chk({4'h0, pwr}, 8'h0E);
        w(8'h19, 8'h01);
        tick(1);
        chk({4'h0, pwr}, 8'h0F);
        w(8'h1A, 8'h01);
        r(8'h14, 8'hEE);
        sg = 4'h0;
        u_host.hw_reset();
        tick(2);
        r(8'h12, 8'hFF);
        for (n = 0; n < 50 && prb[0] !== 1'b1; n++) tick(1);
        for (n = 0; n < 50 && prb[0] !== 1'b0; n++) tick(1);
        for (n = 0; n < 200 && prb[0] !== 1'b1; n++) tick(1);
        chk({7'h0, n >= CAD - 1}, 8'h01);
        sg = 4'hF;
        pw(4'hF);
        temp = 8'h8C;
        tick(2);
        chk({3'h0, therm, pwr}, 8'h10);
        temp = 8'h7D;
        tick(2);
        chk({7'h0, therm}, 8'h01);
        temp = 8'h77;
        tick(2);
        chk({7'h0, therm}, 8'h00);
        conclude();
    end
endmodule
bind psepmc_top psepmc_props #(.PROBE_CYCLES(PROBE_CYCLES)) u_props (
    .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HW_EN_N(HW_EN_N),
    .DIE_TEMP_C(DIE_TEMP_C), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .PORT_POWER(PORT_POWER),
    .PROBE_ACTIVE(PROBE_ACTIVE), .CLASS_ACTIVE(CLASS_ACTIVE),
    .DEV_ADDR(DEV_ADDR), .TIER5_EN(TIER5_EN), .THERM_SHDN(THERM_SHDN));
`default_nettype wire
